// File: core/rsc_defs.svh
// constants for the system-info and custom command interpreter
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// ============================================================
// command codes and request flag bits (bit n at index n-1)
`define RSC_CMD_GSI      8'h2B
`define RSC_CMD_SEC      8'h2C
`define RSC_CMD_FINV     8'hB1
`define RSC_CMD_REFRESH  8'hBC
`define RSC_FLAG_INV     3'd2
`define RSC_FLAG_AFI     3'd4
`define RSC_FLAG_OPT     3'd6
// ============================================================
// reply bytes and error codes
`define RSC_RSP_OK       8'h00
`define RSC_RSP_ERR      8'h01
`define RSC_INFO_FLAG    8'h0F
`define RSC_ERR_BANK     8'h10
`define RSC_ERR_CMD      8'h01
`define RSC_ERR_LOCKED   8'h12
`define RSC_BANK_SYS     8'hFF
`define RSC_BLK_BYTES    32
`define RSC_USER_BLOCKS  256
// ============================================================
// register byte offsets and reset values
`define RSC_REG_UID_LO   8'h00
`define RSC_REG_UID_HI   8'h04
`define RSC_REG_IDENT    8'h08
`define RSC_REG_STATUS   8'h0C
`define RSC_RST_AFI      8'h00
`define RSC_RST_DSFID    8'h00
// ============================================================
// timing: printed figures, clock rate and derived cycle counts
`define RSC_CLK_HZ       100000000
`define RSC_FC_HZ        13560000
`define RSC_T1_NS        320900
`define RSC_SLOT_FC      4096
`define RSC_EOF_TO_MS    38
`define RSC_T1_CYC       ((`RSC_T1_NS * 64'd100 + 64'd999) / 64'd1000)
`define RSC_SLOT_CYC     ((64'(`RSC_SLOT_FC) * 64'(`RSC_CLK_HZ)) / 64'(`RSC_FC_HZ))
`define RSC_EOF_CYC      (64'(`RSC_EOF_TO_MS) * 64'(`RSC_CLK_HZ) / 64'd1000)
`endif

// File: core/rsc_pkg.sv
// types shared by the command interpreter
package rsc_pkg;
  typedef enum logic [2:0] {RSC_IDLE, RSC_CLEAR, RSC_WAIT, RSC_WAIT_EOF, RSC_SEND} rsc_state_type;
  typedef enum logic [2:0] {RSC_K_GSI, RSC_K_SEC, RSC_K_INV, RSC_K_ERR, RSC_K_OK} rsc_kind_type;
endpackage

// File: core/rsc_cmd_core.sv
// command interpreter: system info, security status, fast inventory, refresh
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_cmd_core #(
  parameter int T1_CYC     = int'(`RSC_T1_CYC),     // reply offset after request
  parameter int SLOT_CYC   = int'(`RSC_SLOT_CYC),   // 4096/fc grid step
  parameter int EOF_CYC    = int'(`RSC_EOF_CYC),    // EOF wait timeout
  parameter int BLK_BYTES  = `RSC_BLK_BYTES,        // bytes per block
  parameter int USER_BLKS  = `RSC_USER_BLOCKS,      // user-area blocks
  parameter logic [7:0] MFG_CODE = 8'h5A,           // maker code, value arbitrary
  parameter logic [7:0] IC_REF   = 8'h3C            // IC reference, value arbitrary
) (
  input  wire logic        clk,        // 100 MHz clock
  input  wire logic        rst,        // async reset, active high
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error on unmapped address
  input  wire logic        reqValid,   // decoded request present
  output logic             reqReady,   // interpreter idle
  input  wire logic [7:0]  reqFlags,   // request flag byte
  input  wire logic [7:0]  reqCmd,     // command code
  input  wire logic [7:0]  reqMfg,     // maker code field
  input  wire logic [7:0]  reqAfi,     // optional AFI
  input  wire logic [7:0]  reqFirst,   // first block number
  input  wire logic [7:0]  reqNum,     // block count minus one
  input  wire logic [7:0]  reqBank,    // refresh bank number
  input  wire logic [6:0]  reqMaskLen, // inventory mask length
  input  wire logic [63:0] reqMask,    // inventory mask value
  input  wire logic        reqEof,     // lone EOF pulse
  output logic             txValid,    // reply byte valid
  output logic      [7:0]  txData,     // reply byte
  output logic             txLast,     // last reply byte
  output logic             txFast,     // send at double rate
  input  wire logic        txReady,    // coder took the byte
  output logic      [7:0]  secAddr,    // security status read index
  input  wire logic [7:0]  secData,    // security status, same cycle
  output logic             clrWe,      // zero one user block
  output logic      [7:0]  clrBlk,     // block being zeroed
  output logic             clrSys      // zero system area except UID
);
  import rsc_pkg::*;

  localparam logic [15:0] MSIZE = {3'b000, 5'(BLK_BYTES - 1), 8'(USER_BLKS - 1)};

  rsc_state_type st_q, st_d;
  rsc_kind_type  kind_q, kind_d;
  logic [8:0]  idx_q, idx_d, last_q, last_d, idxM1;
  logic [7:0]  txD_q, txD_d, err_q, err_d, first_q, first_d, clrBlk_q, clrBlk_d;
  logic [7:0]  afi_q, afi_d, dsfid_q, dsfid_d, uidByte;
  logic [31:0] tmr_q, tmr_d, phase_q, phase_d, prd_q, prd_d;
  logic [63:0] uid_q, uid_d, lenMask;
  logic [1:0]  bank_q, bank_d;
  logic txV_q, txV_d, txF_q, txF_d, opt_q, opt_d, sys_q, sys_d, sysDone_q, sysDone_d;
  logic clrWe_q, clrWe_d, clrSys_q, clrSys_d, start, wipe, afiOk, maskOk, apbWr, mapped;

  // ============================================================
  // request qualifiers
  // anti-collision slots are not modelled: a matching tag always answers at once
  assign lenMask = ~(64'hFFFF_FFFF_FFFF_FFFF << reqMaskLen);
  assign maskOk  = (reqMaskLen <= 7'd64) && (((reqMask ^ uid_q) & lenMask) == 64'h0000_0000_0000_0000);
  // a zero nibble in the request acts as a wildcard for that nibble
  assign afiOk = !reqFlags[`RSC_FLAG_AFI] || (reqAfi == 8'h00) || (reqAfi == afi_q) ||
                 (reqAfi[7:4] == 4'h0 && reqAfi[3:0] == afi_q[3:0]) ||
                 (reqAfi[3:0] == 4'h0 && reqAfi[7:4] == afi_q[7:4]);
  assign idxM1   = idx_q - 9'd1;
  assign uidByte = uid_q[{idxM1[2:0], 3'b000} +: 8];     // uid goes out lsb byte first
  assign secAddr = first_q + idx_q[7:0];                  // block for the byte after this one

  // ============================================================
  // command sequencing and reply serializer
  always_comb begin
    st_d = st_q; kind_d = kind_q; idx_d = idx_q; last_d = last_q;
    txV_d = txV_q; txD_d = txD_q; txF_d = txF_q; err_d = err_q;
    first_d = first_q; opt_d = opt_q; sys_d = sys_q; bank_d = bank_q;
    sysDone_d = sysDone_q; clrBlk_d = clrBlk_q;
    clrWe_d = 1'b0; clrSys_d = 1'b0; start = 1'b0; wipe = 1'b0;
    tmr_d = tmr_q + 32'd1;
    // reply grid phase starts counting once the T1 offset is reached
    phase_d = (tmr_q >= 32'(T1_CYC - 1)) ? ((phase_q == 32'(SLOT_CYC - 1)) ? 32'd0 : phase_q + 32'd1) : 32'd0;
    case (st_q)
      RSC_IDLE: begin
        if (reqValid) begin
          tmr_d = 32'd0;
          phase_d = 32'd0;
          case (reqCmd)
            `RSC_CMD_GSI: begin
              kind_d = RSC_K_GSI; last_d = 9'd14; start = 1'b1;
            end
            `RSC_CMD_SEC: begin
              kind_d = RSC_K_SEC; first_d = reqFirst;
              last_d = {1'b0, reqNum} + 9'd1; start = 1'b1;
            end
            `RSC_CMD_FINV: begin
              // any fault just drops the request silently
              if (reqMfg == MFG_CODE && reqFlags[`RSC_FLAG_INV] && afiOk && maskOk) begin
                kind_d = RSC_K_INV; last_d = 9'd9; start = 1'b1;
              end
            end
            `RSC_CMD_REFRESH: begin
              if (reqMfg == MFG_CODE) begin
                opt_d = reqFlags[`RSC_FLAG_OPT];
                sys_d = (reqBank == `RSC_BANK_SYS);
                bank_d = reqBank[1:0];
                if (reqBank[7:2] != 6'd0 && reqBank != `RSC_BANK_SYS) begin
                  kind_d = RSC_K_ERR; err_d = `RSC_ERR_BANK; last_d = 9'd1; start = 1'b1;
                end else if (reqBank == `RSC_BANK_SYS && sysDone_q) begin
                  kind_d = RSC_K_ERR; err_d = `RSC_ERR_LOCKED; last_d = 9'd1; start = 1'b1;
                end else begin
                  st_d = RSC_CLEAR; idx_d = 9'd0;
                end
              end
            end
            default: begin
              kind_d = RSC_K_ERR; err_d = `RSC_ERR_CMD; last_d = 9'd1; start = 1'b1;
            end
          endcase
        end
      end
      RSC_CLEAR: begin
        // one block per cycle, so a user bank takes 64 cycles before a reply can start
        if (sys_q) begin
          // uid is held apart from the wiped system area
          clrSys_d = 1'b1; sysDone_d = 1'b1; wipe = 1'b1;
          st_d = opt_q ? RSC_WAIT_EOF : RSC_WAIT;
        end else begin
          clrWe_d = 1'b1; clrBlk_d = {bank_q, idx_q[5:0]};
          idx_d = idx_q + 9'd1;
          if (idx_q[5:0] == 6'h3F) st_d = opt_q ? RSC_WAIT_EOF : RSC_WAIT;
        end
      end
      RSC_WAIT: begin
        // a clear that outruns T1 lands on a later grid point; the 20 ms ceiling is not watched
        if (tmr_q >= 32'(T1_CYC - 1) && phase_q == 32'd0) begin
          kind_d = RSC_K_OK; last_d = 9'd0; start = 1'b1;
        end
      end
      RSC_WAIT_EOF: begin
        if (reqEof) begin
          kind_d = RSC_K_OK; last_d = 9'd0; start = 1'b1;
        end else if (tmr_q >= 32'(EOF_CYC - 1)) begin
          st_d = RSC_IDLE;
        end
      end
      RSC_SEND: begin
        if (txReady) begin
          if (idx_q == last_q) begin
            txV_d = 1'b0; st_d = RSC_IDLE;
          end else begin
            idx_d = idx_q + 9'd1;
            case (kind_q)
              RSC_K_GSI: begin
                case (idx_d)
                  9'd1:    txD_d = `RSC_INFO_FLAG;
                  9'd10:   txD_d = dsfid_q;
                  9'd11:   txD_d = afi_q;
                  9'd12:   txD_d = MSIZE[7:0];
                  9'd13:   txD_d = MSIZE[15:8];
                  9'd14:   txD_d = IC_REF;
                  default: txD_d = uidByte;
                endcase
              end
              RSC_K_INV: txD_d = (idx_d == 9'd1) ? dsfid_q : uidByte;
              RSC_K_SEC: txD_d = secData;
              default:   txD_d = err_q;
            endcase
          end
        end
      end
      default: st_d = RSC_IDLE;
    endcase
    if (start) begin
      st_d = RSC_SEND; idx_d = 9'd0; txV_d = 1'b1;
      txD_d = (kind_d == RSC_K_ERR) ? `RSC_RSP_ERR : `RSC_RSP_OK;
      txF_d = (kind_d == RSC_K_INV);
    end
  end

  // ============================================================
  // apb slave: zero wait states, error on unmapped offsets
  assign apbWr  = psel && penable && pwrite;
  assign mapped = (paddr == `RSC_REG_UID_LO) || (paddr == `RSC_REG_UID_HI) ||
                  (paddr == `RSC_REG_IDENT) || (paddr == `RSC_REG_STATUS);
  always_comb begin
    uid_d = uid_q; afi_d = afi_q; dsfid_d = dsfid_q; prd_d = prd_q;
    if (apbWr && paddr == `RSC_REG_UID_LO) uid_d[31:0] = pwdata;
    if (apbWr && paddr == `RSC_REG_UID_HI) uid_d[63:32] = pwdata;
    if (apbWr && paddr == `RSC_REG_IDENT) begin
      afi_d = pwdata[7:0]; dsfid_d = pwdata[15:8];
    end
    // the system wipe lands after any same-cycle software write
    if (wipe) begin
      afi_d = 8'h00; dsfid_d = 8'h00;
    end
    if (psel && !penable) begin
      case (paddr)
        `RSC_REG_UID_LO: prd_d = uid_q[31:0];
        `RSC_REG_UID_HI: prd_d = uid_q[63:32];
        `RSC_REG_IDENT:  prd_d = {8'h00, IC_REF, dsfid_q, afi_q};
        `RSC_REG_STATUS: prd_d = {16'h0000, err_q, 6'd0, (st_q != RSC_IDLE), sysDone_q};
        default:         prd_d = 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // state registers
  // limitation: the once-only system lock is lost at reset, it lasts one power cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= RSC_IDLE; kind_q <= RSC_K_OK; idx_q <= 9'd0; last_q <= 9'd0;
      txV_q <= 1'b0; txD_q <= 8'h00; txF_q <= 1'b0; err_q <= 8'h00;
      first_q <= 8'h00; opt_q <= 1'b0; sys_q <= 1'b0; bank_q <= 2'd0;
      sysDone_q <= 1'b0; clrBlk_q <= 8'h00; clrWe_q <= 1'b0; clrSys_q <= 1'b0;
      tmr_q <= 32'd0; phase_q <= 32'd0; prd_q <= 32'h0000_0000;
      uid_q <= 64'h0000_0000_0000_0000; afi_q <= `RSC_RST_AFI; dsfid_q <= `RSC_RST_DSFID;
    end else begin
      st_q <= st_d; kind_q <= kind_d; idx_q <= idx_d; last_q <= last_d;
      txV_q <= txV_d; txD_q <= txD_d; txF_q <= txF_d; err_q <= err_d;
      first_q <= first_d; opt_q <= opt_d; sys_q <= sys_d; bank_q <= bank_d;
      sysDone_q <= sysDone_d; clrBlk_q <= clrBlk_d; clrWe_q <= clrWe_d; clrSys_q <= clrSys_d;
      tmr_q <= tmr_d; phase_q <= phase_d; prd_q <= prd_d;
      uid_q <= uid_d; afi_q <= afi_d; dsfid_q <= dsfid_d;
    end
  end

  // prdata, txData, txValid, txFast and the clear outputs come straight from registers; secAddr, txLast, pslverr and reqReady are combinational
  assign prdata   = prd_q;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign reqReady = (st_q == RSC_IDLE);
  assign txValid  = txV_q;
  assign txData   = txD_q;
  assign txFast   = txF_q;
  assign txLast   = txV_q && (idx_q == last_q);
  assign clrWe    = clrWe_q;
  assign clrBlk   = clrBlk_q;
  assign clrSys   = clrSys_q;

  // ============================================================
  // assertions
  logic refReq, ok0;
  assign refReq = reqValid && reqReady && reqCmd == `RSC_CMD_REFRESH && reqMfg == MFG_CODE;
  assign ok0 = txValid && idx_q == 9'd0;
  property p_infoFlag; @(posedge clk) disable iff (rst)
    txValid && kind_q == RSC_K_GSI && idx_q == 9'd1 |-> txData == `RSC_INFO_FLAG; endproperty
  a_infoFlag: assert property (p_infoFlag) else $error("info flag not 0F");
  property p_gsiLast; @(posedge clk) disable iff (rst)
    txLast && kind_q == RSC_K_GSI |-> idx_q == 9'd14; endproperty
  a_gsiLast: assert property (p_gsiLast) else $error("info reply length wrong");
  property p_msize; @(posedge clk) disable iff (rst)
    txValid && kind_q == RSC_K_GSI && idx_q == 9'd12 && txReady |=> txData == MSIZE[15:8]; endproperty
  a_msize: assert property (p_msize) else $error("memory size high byte wrong");
  property p_secLen; @(posedge clk) disable iff (rst)
    reqValid && reqReady && reqCmd == `RSC_CMD_SEC |=> last_q == {1'b0, $past(reqNum)} + 9'd1; endproperty
  a_secLen: assert property (p_secLen) else $error("security reply length wrong");
  property p_fast; @(posedge clk) disable iff (rst)
    txValid |-> txFast == (kind_q == RSC_K_INV); endproperty
  a_fast: assert property (p_fast) else $error("rate select wrong");
  property p_invDrop; @(posedge clk) disable iff (rst)
    reqValid && reqReady && reqCmd == `RSC_CMD_FINV && !(afiOk && maskOk) |=> st_q == RSC_IDLE && !txValid;
  endproperty
  a_invDrop: assert property (p_invDrop) else $error("inventory answered on error");
  property p_bankErr; @(posedge clk) disable iff (rst)
    refReq && reqBank[7:2] != 6'd0 && reqBank != `RSC_BANK_SYS |=> ok0 && txData == `RSC_RSP_ERR ##1 err_q == `RSC_ERR_BANK;
  endproperty
  a_bankErr: assert property (p_bankErr) else $error("bad bank not refused");
  property p_sysOnce; @(posedge clk) disable iff (rst)
    refReq && reqBank == `RSC_BANK_SYS && sysDone_q |=> !clrSys [*3]; endproperty
  a_sysOnce: assert property (p_sysOnce) else $error("system area refreshed twice");
  property p_userBank; @(posedge clk) disable iff (rst)
    clrWe |-> clrBlk[7:6] == bank_q && !sys_q; endproperty
  a_userBank: assert property (p_userBank) else $error("cleared block outside bank");
  property p_t1; @(posedge clk) disable iff (rst)
    $rose(txValid) && kind_q == RSC_K_OK && !opt_q |-> tmr_q >= 32'(T1_CYC); endproperty
  a_t1: assert property (p_t1) else $error("refresh reply too early");
  property p_eofTo; @(posedge clk) disable iff (rst)
    st_q == RSC_WAIT_EOF && !reqEof && tmr_q >= 32'(EOF_CYC - 1) |=> st_q == RSC_IDLE && !txValid; endproperty
  a_eofTo: assert property (p_eofTo) else $error("EOF wait did not time out");
  property p_errFlag; @(posedge clk) disable iff (rst)
    ok0 |-> txData == ((kind_q == RSC_K_ERR) ? `RSC_RSP_ERR : `RSC_RSP_OK); endproperty
  a_errFlag: assert property (p_errFlag) else $error("reply flag byte wrong");
  // the system wipe must clear the identity bytes held in this block
  property p_wipeId; @(posedge clk) disable iff (rst)
    wipe |=> afi_q == 8'h00 && dsfid_q == 8'h00; endproperty
  a_wipeId: assert property (p_wipeId) else $error("identity bytes survived wipe");
  // each clear-state cycle of a user bank zeroes exactly the block it indexes
  property p_clrStart; @(posedge clk) disable iff (rst)
    st_q == RSC_CLEAR && !sys_q |=> clrWe && clrBlk[5:0] == $past(idx_q[5:0]); endproperty
  a_clrStart: assert property (p_clrStart) else $error("user block clear missing");
  // the byte after the flag of an inventory reply is the DSFID
  property p_invDsfid; @(posedge clk) disable iff (rst)
    txValid && kind_q == RSC_K_INV && idx_q == 9'd1 |-> txData == dsfid_q; endproperty
  a_invDsfid: assert property (p_invDsfid) else $error("inventory reply order wrong");
  // every status byte is the stored one for its block
  property p_secByte; @(posedge clk) disable iff (rst)
    txValid && kind_q == RSC_K_SEC && txReady && idx_q != last_q |=> txData == $past(secData); endproperty
  a_secByte: assert property (p_secByte) else $error("security byte wrong");
  c_sec: cover property (@(posedge clk) disable iff (rst) txLast && kind_q == RSC_K_SEC);
  c_gsi: cover property (@(posedge clk) disable iff (rst) txLast && kind_q == RSC_K_GSI);
  c_inv: cover property (@(posedge clk) disable iff (rst) txLast && kind_q == RSC_K_INV);
  c_sys: cover property (@(posedge clk) disable iff (rst) clrSys);
  c_eof: cover property (@(posedge clk) disable iff (rst) st_q == RSC_WAIT_EOF && reqEof);
endmodule // rsc_cmd_core

// File: test/rsc_reader_model.sv
// far-side model: reply byte sink with optional stall, plus the security-status store
`timescale 1ns/1ps
module rsc_reader_model (
  input  wire logic       clk,     // bench clock
  input  wire logic       rst,     // async reset, active high
  input  wire logic       slow,    // drop ready every other cycle
  input  wire logic       txValid, // reply byte valid
  input  wire logic [7:0] txData,  // reply byte
  input  wire logic       txLast,  // last reply byte
  input  wire logic       txFast,  // double-rate marker
  output logic            txReady, // byte taken
  input  wire logic [7:0] secAddr, // status index
  output logic      [7:0] secData  // status byte, same cycle
);
  logic [7:0] got [$];
  logic       fastSeen;
  int         nReply;
  // ============================================================
  // status store: a fixed pattern so every block's byte is predictable
  assign secData = secAddr ^ 8'hA5;
  // ============================================================
  // byte sink: when slow, ready toggles so the design must hold its byte
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
      nReply  <= 0;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      if (txValid === 1'b1 && txReady === 1'b1) begin
        got.push_back(txData);
        fastSeen <= txFast;
        if (txLast === 1'b1) nReply <= nReply + 1;
      end
    end
  end
endmodule // rsc_reader_model

// File: test/rsc_cmd_core_tb_top.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module rsc_cmd_core_tb_top;
  localparam int T1 = 100;
  localparam int EOFC = 300;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic        reqValid, reqReady, reqEof, txValid, txLast, txFast, txReady, clrWe, clrSys;
  logic [7:0]  paddr, reqFlags, reqCmd, reqMfg, reqAfi, reqFirst, reqNum, reqBank, txData, secAddr, secData, clrBlk;
  logic [6:0]  reqMaskLen;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] uid, reqMask;
  logic        err;
  int          miscompares, checks_done, clrCnt, sysCnt, lat;
  logic [7:0]  clrFirst, clrLast;
  logic [7:0]  q [$];
  // ============================================================
  // design and far-side model; short timing counts keep the run brief
  rsc_cmd_core #(.T1_CYC(T1), .SLOT_CYC(50), .EOF_CYC(EOFC)) i_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqValid(reqValid), .reqReady(reqReady), .reqFlags(reqFlags), .reqCmd(reqCmd),
    .reqMfg(reqMfg), .reqAfi(reqAfi), .reqFirst(reqFirst), .reqNum(reqNum), .reqBank(reqBank),
    .reqMaskLen(reqMaskLen), .reqMask(reqMask), .reqEof(reqEof), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txFast(txFast), .txReady(txReady), .secAddr(secAddr),
    .secData(secData), .clrWe(clrWe), .clrBlk(clrBlk), .clrSys(clrSys));
  rsc_reader_model i_rdr (.clk(clk), .rst(rst), .slow(slow), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txFast(txFast), .txReady(txReady), .secAddr(secAddr), .secData(secData));
  // ============================================================
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1, "apb ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // offer a request, then count cycles until the first reply byte (lim if none)
  task automatic req(input logic [7:0] fl, cmd, mfg, arg, first, num, input logic [6:0] ml, input int lim);
    int n;
    i_rdr.got.delete();
    @(posedge clk);
    reqValid <= 1'b1;
    reqFlags <= fl;
    reqCmd <= cmd;
    reqMfg <= mfg;
    reqAfi <= arg;
    reqBank <= arg;
    reqFirst <= first;
    reqNum <= num;
    reqMaskLen <= ml;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 100);
    chk(reqReady, 1'b1, "request taken");
    reqValid <= 1'b0;
    for (lat = 0; lat < lim && txValid !== 1'b1; lat++) @(posedge clk);
  endtask
  // wait for the closing byte, then compare the whole reply
  task automatic expect_reply(input logic [7:0] e [$]);
    int n, start;
    start = i_rdr.nReply;
    for (n = 0; n < 2000 && i_rdr.nReply == start; n++) @(posedge clk);
    chk(i_rdr.got.size(), e.size(), "reply length");
    foreach (e[i]) chk(i_rdr.got[i], e[i], "reply byte");
  endtask
  function automatic void push_uid();
    for (int i = 0; i < 8; i++) q.push_back(uid[8*i+:8]);
  endfunction
  // ============================================================
  // scenarios
  task automatic t_gsi();
    apb(1'b1, 8'h08, 32'h0000_7C35);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h003C_7C35, "ident");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({err, rd}, 33'h1_0000_0000, "unmapped");
    uid = 64'h8877_6655_4433_2211;
    apb(1'b1, 8'h00, uid[31:0]);
    apb(1'b1, 8'h04, uid[63:32]);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, uid[31:0], "uid low word");
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, uid[63:32], "uid high word");
    slow <= 1'b1;
    req(8'h00, 8'h2B, 8'h00, 8'h00, 8'h00, 8'h00, 7'd0, 20);
    q = {8'h00, 8'h0F};
    push_uid();
    q = {q, 8'h7C, 8'h35, 8'hFF, 8'h1F, 8'h3C};
    expect_reply(q);
    chk(i_rdr.fastSeen, 1'b0, "gsi rate");
    slow <= 1'b0;
  endtask
  task automatic t_sec();
    logic [7:0] f [2] = '{8'h08, 8'hF8};
    logic [7:0] c [2] = '{8'h03, 8'h07};
    for (int k = 0; k < 2; k++) begin
      req(8'h00, 8'h2C, 8'h00, 8'h00, f[k], c[k], 7'd0, 20);
      q = {8'h00};
      for (int b = 0; b <= c[k]; b++) q.push_back((f[k] + 8'(b)) ^ 8'hA5);
      expect_reply(q);
    end
  endtask
  task automatic t_finv();
    logic [7:0] fl [12] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h10, 8'h14, 8'h14, 8'h04};
    logic [7:0] af [12] = '{8'h35, 8'h00, 8'h05, 8'h30, 8'h36, 8'h45, 8'h06, 8'h50, 8'h35, 8'h35, 8'h35, 8'h99};
    logic [7:0] mf [12] = '{default: 8'h5A, 9: 8'h5B};
    logic [6:0] ml [12] = '{default: 7'd0, 10: 7'd65, 11: 7'd64};
    logic       ok [12] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 1};
    reqMask <= uid;
    for (int k = 0; k < 12; k++) begin
      req(fl[k], 8'hB1, mf[k], af[k], 8'h00, 8'h00, ml[k], 20);
      if (ok[k]) begin
        q = {8'h00, 8'h7C};
        push_uid();
        expect_reply(q);
        chk(i_rdr.fastSeen, 1'b1, "fast rate");
      end else begin
        chk({lat, reqReady}, {20, 1'b1}, "silent inventory");
      end
    end
  endtask
  task automatic t_refresh();
    for (int k = 0; k < 5; k++) begin
      clrCnt = 0;
      req(8'h00, 8'hBC, 8'h5A, 8'(k % 4), 8'h00, 8'h00, 7'd0, 400);
      chk(lat >= T1 && lat <= T1 + 2, 1'b1, "refresh reply time");
      expect_reply('{8'h00});
      chk({clrCnt, clrFirst, clrLast}, {64, 8'(k % 4 * 64), 8'(k % 4 * 64 + 63)}, "bank blocks");
    end
    req(8'h00, 8'hBC, 8'h5A, 8'h04, 8'h00, 8'h00, 7'd0, 400);
    expect_reply('{8'h01, 8'h10});
    req(8'h00, 8'h99, 8'h5A, 8'h00, 8'h00, 8'h00, 7'd0, 20);
    expect_reply('{8'h01, 8'h01});
    for (int k = 0; k < 2; k++) begin
      req(8'h00, 8'hBC, 8'h5A, 8'hFF, 8'h00, 8'h00, 7'd0, 400);
      if (k == 0) expect_reply('{8'h00});
      else expect_reply('{8'h01, 8'h12});
      chk(sysCnt, 1, "system wipes");
    end
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h003C_0000, "ident wiped");
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, uid[31:0], "uid kept");
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_1201, "status after system refresh");
  endtask
  // mid-run reset: reqReady, txValid, clrSys and the status and uid registers return to their reset values
  task automatic t_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({reqReady, txValid, clrSys}, 3'b100, "reset outputs");
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status after reset");
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "uid after reset");
  endtask
  task automatic t_eof();
    req(8'h40, 8'hBC, 8'h5A, 8'h02, 8'h00, 8'h00, 7'd0, 120);
    chk(lat, 120, "held for eof");
    reqEof <= 1'b1;
    @(posedge clk);
    reqEof <= 1'b0;
    expect_reply('{8'h00});
    req(8'h40, 8'hBC, 8'h5A, 8'h01, 8'h00, 8'h00, 7'd0, EOFC - 20);
    chk(reqReady, 1'b0, "busy before timeout");
    repeat (40) @(posedge clk);
    chk({reqReady, txValid}, 2'b10, "eof timeout");
  endtask
  // ============================================================
  // clear-strobe monitor: first and last block and pulse counts
  always @(posedge clk) begin
    if (clrWe === 1'b1) begin
      if (clrCnt == 0) clrFirst = clrBlk;
      clrLast = clrBlk;
      clrCnt++;
    end
    if (clrSys === 1'b1) sysCnt++;
  end
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, reqValid, reqEof} = '0;
    {reqFlags, reqCmd, reqMfg, reqAfi, reqFirst, reqNum, reqBank, reqMaskLen, reqMask} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_gsi();
    t_sec();
    t_finv();
    t_refresh();
    t_eof();
    t_rst();
    finish_test();
  end
endmodule // rsc_cmd_core_tb_top
